// ===== dv/gct_front_end.sv
// Analog front end model: receive framing and attenuator switches
`timescale 1ns/1ns
module gct_front_end (
    input  wire logic        clock,
    input  wire logic [15:0] level,
    input  wire logic        frameReq,
    input  wire logic        attenFirst,
    input  wire logic        attenSecond,
    output logic      [15:0] rxAmplitude,
    output logic             rxMessageActive,
    output logic      [1:0]  attenState
);
    logic [15:0] noise = 16'h5A5A;
    // Outside frames the amplitude wanders, so no stale value looks valid
    always @(posedge clock) begin
        noise           <= noise + 16'h3C1D;
        rxMessageActive <= frameReq;
        rxAmplitude     <= frameReq ? level : noise;
        attenState      <= {attenSecond, attenFirst};
    end
endmodule

// ===== dv/gct_gain_control_asserts.sv
// Port checker for the gain control block
`timescale 1ns/1ns
module gct_chk
    import gct_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        clockEnable,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbWe,
    input wire logic [15:0] wbAdr,
    input wire logic [7:0]  wbDatW,
    input wire logic        wbSel,
    input wire logic [7:0]  wbDatR,
    input wire logic        wbAck,
    input wire logic [15:0] rxAmplitude,
    input wire logic        rxMessageActive,
    input wire logic        portTimerOutput,
    input wire logic        gainOutFirst,
    input wire logic        gainOutSecond,
    input wire logic        sharedPinOut
);
    logic [7:0] cfg_r, cfg_nxt, pin_r, pin_nxt;
    logic [3:0] q_r, q_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
    logic       wr, f0, f1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Shadow of config from bus writes, since the ports hide the modes
    always_comb begin
        wr = wbCyc && wbStb && wbWe && wbSel && wbAck;
        cfg_nxt = cfg_r;
        pin_nxt = pin_r;
        if (wr && wbAdr == ADDR_GAIN_CONFIG) cfg_nxt = wbDatW & CFG_MASK;
        if (wr && wbAdr == ADDR_PIN_ROUTING) pin_nxt = wbDatW & PIN_MASK;
        q_nxt = wr ? 4'h0 : q_r + {3'h0, q_r != 4'hF};
        hi_nxt = rxMessageActive ? hi_r + {3'h0, hi_r != 4'hF} : 4'h0;
        lo_nxt = rxMessageActive ? 4'h0 : lo_r + {3'h0, lo_r != 4'hF};
        f0 = cfg_r[4] ~^ cfg_r[5];
        f1 = cfg_r[1] ~^ cfg_r[2];
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_r <= RST_GAIN_CONFIG;
            pin_r <= RST_PIN_ROUTING;
            q_r   <= 4'h0;
            hi_r  <= 4'h0;
            lo_r  <= 4'h0;
        end else begin
            cfg_r <= cfg_nxt;
            pin_r <= pin_nxt;
            q_r   <= q_nxt;
            hi_r  <= hi_nxt;
            lo_r  <= lo_nxt;
        end
    end
    ack_pulse_a: assert property (
        wbAck && clockEnable |=> !wbAck) else $error("ack held too long");
    ack_timing_a: assert property (
        wbCyc && wbStb && !wbAck && clockEnable |=> wbAck)
        else $error("ack late");
    ack_idle_a: assert property (
        !wbCyc |=> !wbAck) else $error("ack without request");
    forced_first_a: assert property (
        q_r >= 4 && cfg_r[3] && cfg_r[0] |->
        gainOutFirst == (pin_r[0] ? f1 : f0)) else $error("first wrong");
    forced_second_a: assert property (
        q_r >= 4 && cfg_r[3] && cfg_r[0] |->
        gainOutSecond == (pin_r[0] ? f0 : f1)) else $error("second wrong");
    idle_level_a: assert property (
        q_r >= 8 && lo_r >= 8 && !cfg_r[3] && !pin_r[0] |->
        gainOutFirst == !cfg_r[5]) else $error("idle level wrong");
    hold_out_a: assert property (
        hi_r >= 7 && rxMessageActive && q_r >= 4 && !cfg_r[3] && !cfg_r[0]
        |-> $stable(gainOutFirst) && $stable(gainOutSecond))
        else $error("output moved in message");
    shared_pin_a: assert property (
        (pin_r[1] && q_r >= 4 && $stable(gainOutSecond)) [*3] |->
        sharedPinOut == gainOutSecond) else $error("shared pin wrong");
    port_pin_a: assert property (
        (!pin_r[1] && q_r >= 4 && $stable(portTimerOutput)) [*6] |->
        sharedPinOut == portTimerOutput) else $error("port pin wrong");
    cover property (q_r >= 4 && cfg_r[3] && pin_r[0]);
    cover property (hi_r >= 7 && gainOutFirst && gainOutSecond);
    cover property (pin_r[1] && sharedPinOut);
endmodule

bind gct_gain_control gct_chk u_chk (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbDatW(wbDatW), .wbSel(wbSel), .wbDatR(wbDatR),
    .wbAck(wbAck), .rxAmplitude(rxAmplitude),
    .rxMessageActive(rxMessageActive), .portTimerOutput(portTimerOutput),
    .gainOutFirst(gainOutFirst), .gainOutSecond(gainOutSecond),
    .sharedPinOut(sharedPinOut));

// ===== dv/gct_testbench.sv
// Self-checking bench for the gain control block
`timescale 1ns/1ns
module testbench;
    import gct_pkg::*;
    logic        clock = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
    logic        wbWe = 1'b0, frameReq = 1'b0, portTimerOutput = 1'b0;
    logic        wbSel = 1'b1, selOn = 1'b1;
    logic        wbAck, rxMessageActive, gainOutFirst, gainOutSecond;
    logic        sharedPinOut;
    logic [15:0] wbAdr = 16'h0000, level = 16'h0000, rxAmplitude;
    logic [7:0]  wbDatW = 8'h00, wbDatR, rd;
    logic [1:0]  attenState;
    int          bad_count = 0, n_checks = 0;
    logic [15:0] adrs [9] = '{ADDR_GAIN1_TH_HI, ADDR_GAIN1_TH_LO,
        ADDR_PIN_ROUTING, ADDR_GAIN_CONFIG, ADDR_GAIN0_TH_HI,
        ADDR_GAIN0_TH_LO, ADDR_SATURATION_THRESHOLD_HI, ADDR_SATURATION_THRESHOLD_LO, 16'hFE00};
    logic [7:0]  rsts [9] = '{8'h40, 8'h00, 8'h00, 8'h24, 8'h10, 8'h00,
        8'h40, 8'h00, 8'h00};
    logic [15:0] amps [4] = '{16'h37AA, 16'h37AB, 16'h4A00, 16'h4A01};
    logic [1:0]  outs [4] = '{2'b00, 2'b01, 2'b01, 2'b11};
    always #5 clock = ~clock;
    gct_gain_control dut (.clock(clock), .reset(reset), .clockEnable(1'b1),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbDatW(wbDatW), .wbSel(wbSel), .wbDatR(wbDatR), .wbAck(wbAck),
        .rxAmplitude(rxAmplitude), .rxMessageActive(rxMessageActive),
        .portTimerOutput(portTimerOutput), .gainOutFirst(gainOutFirst),
        .gainOutSecond(gainOutSecond), .sharedPinOut(sharedPinOut));
    gct_front_end fe (.clock(clock), .level(level), .frameReq(frameReq),
        .attenFirst(gainOutFirst), .attenSecond(gainOutSecond),
        .rxAmplitude(rxAmplitude), .rxMessageActive(rxMessageActive),
        .attenState(attenState));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Classic cycle; no fixed latency assumed, only the bounded wait
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatW <= d;
        wbSel <= selOn;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) bad_count++;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        check(16'(rd), 16'(e));
    endtask
    task automatic wr16(input logic [15:0] a, input logic [15:0] v);
        wb(1'b1, a, v[15:8]);
        wb(1'b1, a + 16'h0001, v[7:0]);
    endtask
    task automatic frame(input logic [15:0] amp, input logic [1:0] exp);
        level <= amp;
        frameReq <= 1'b1;
        repeat (8) @(posedge clock);
        check(16'(attenState), 16'(exp));
        level <= ~amp;
        repeat (6) @(posedge clock);
        check(16'(attenState), 16'(exp));
        frameReq <= 1'b0;
        repeat (10) @(posedge clock);
        check(16'(attenState), 16'h0000);
    endtask
    task automatic outs2(input logic [1:0] e);
        repeat (4) @(posedge clock);
        check(16'({gainOutSecond, gainOutFirst}), 16'(e));
    endtask
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) rdchk(adrs[i], rsts[i]);
        $display("test reset values done");
        wr16(ADDR_SATURATION_THRESHOLD_HI, 16'h37AA);
        wr16(ADDR_GAIN1_TH_HI, 16'h4A00);
        wr16(ADDR_GAIN0_TH_HI, 16'h1000);
        rdchk(ADDR_SATURATION_THRESHOLD_HI, 8'h37);
        selOn = 1'b0;
        wb(1'b1, ADDR_GAIN0_TH_LO, 8'h55);
        selOn = 1'b1;
        rdchk(ADDR_GAIN0_TH_LO, 8'h00);
        wb(1'b1, 16'hFE00, 8'hFF);
        rdchk(16'hFE00, 8'h00);
        for (int i = 0; i < 4; i++) frame(amps[i], outs[i]);
        wr16(ADDR_GAIN0_TH_HI, 16'h5000);
        frame(16'h4A01, 2'b10);
        rdchk(ADDR_STATUS, 8'h04);
        $display("test automatic done");
        wb(1'b1, ADDR_GAIN_CONFIG, 8'h04);
        outs2(2'b01);
        $display("test polarity done");
        for (int v = 0; v < 4; v++) begin
            wb(1'b1, ADDR_GAIN_CONFIG, 8'h2D | {3'h0, v[0], 2'h0, v[1], 1'b0});
            outs2({v[1], v[0]});
        end
        wb(1'b1, ADDR_GAIN_CONFIG, 8'h19);
        outs2(2'b10);
        wb(1'b1, ADDR_GAIN_CONFIG, 8'h2D);
        frame(16'h5001, 2'b00);
        wb(1'b1, ADDR_GAIN_CONFIG, 8'hFF);
        rdchk(ADDR_GAIN_CONFIG, 8'h3F);
        $display("test forced done");
        wb(1'b1, ADDR_GAIN_CONFIG, 8'h3D);
        wb(1'b1, ADDR_PIN_ROUTING, 8'h01);
        outs2(2'b10);
        wb(1'b1, ADDR_PIN_ROUTING, 8'hFF);
        rdchk(ADDR_PIN_ROUTING, 8'h03);
        repeat (4) @(posedge clock);
        check(16'(sharedPinOut), 16'h0001);
        wb(1'b1, ADDR_PIN_ROUTING, 8'h00);
        portTimerOutput <= 1'b1;
        outs2(2'b01);
        repeat (4) @(posedge clock);
        check(16'(sharedPinOut), 16'h0001);
        portTimerOutput <= 1'b0;
        repeat (8) @(posedge clock);
        check(16'(sharedPinOut), 16'h0000);
        $display("test pins done");
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rdchk(ADDR_GAIN_CONFIG, RST_GAIN_CONFIG);
        rdchk(ADDR_SATURATION_THRESHOLD_HI, RST_SATURATION_THRESHOLD_HI);
        $display("test second reset done");
        conclude();
    end
    // Whole run needs under 2000 cycles
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule

// ===== src/gct_channel_decide.sv
// Per-channel decision: automatic or forced value, then polarity
`timescale 1ns/1ns
module gct_channel_decide
    import gct_pkg::*;
(
    input  wire logic [15:0] amplitude,
    input  wire logic [15:0] threshold,
    input  wire logic        satExceeded,
    input  wire logic        modeSelect,
    input  wire logic        forcedValue,
    input  wire logic        polarity,
    output logic             decided
);
    logic raw;

    always_comb begin
        if (modeSelect == MODE_AUTO) begin
            // Threshold only counts once saturation is exceeded
            raw = satExceeded && (amplitude > threshold);
        end else begin
            raw = forcedValue;
        end
        decided = polarity ? raw : ~raw;
    end
endmodule

// ===== src/gct_gain_control.sv
// Receive-path gain control with threshold registers on Wishbone
// Functional notes
// - 16-bit saturation threshold, high byte at lower address.
// - Above saturation threshold, the threshold of each automatic-mode channel is evaluated.
// - Not above saturation threshold, gain thresholds ignored, no attenuation in automatic mode.
// - Second channel 16-bit upper threshold, high byte lower address.
// - Second threshold acts only in automatic mode and past saturation.
// - First channel 16-bit upper threshold, high byte lower address.
// - First threshold acts only in automatic mode and past saturation.
// - Swap bit exchanges first and second gain outputs.
// - Automatic mode outputs one past saturation and above its threshold, else zero, pre-polarity.
// - Forced mode outputs the written value bit, polarity applied.
// - Polarity one passes output, zero inverts it; default one.
// - Automatic-mode outputs decided at message start and held until message end; forced outputs follow writes at once.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
module gct_gain_control
    import gct_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clockEnable,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [15:0] wbAdr,
    input  wire logic [7:0]  wbDatW,
    input  wire logic        wbSel,
    output logic      [7:0]  wbDatR,
    output logic             wbAck,
    input  wire logic [15:0] rxAmplitude,
    input  wire logic        rxMessageActive,
    input  wire logic        portTimerOutput,
    output logic             gainOutFirst,
    output logic             gainOutSecond,
    output logic             sharedPinOut
);
    // Register file
    logic [7:0] gain1ThHi_r, gain1ThHi_nxt;
    logic [7:0] gain1ThLo_r, gain1ThLo_nxt;
    logic [7:0] pinRouting_r, pinRouting_nxt;
    logic [7:0] gainConfig_r, gainConfig_nxt;
    logic [7:0] gain0ThHi_r, gain0ThHi_nxt;
    logic [7:0] gain0ThLo_r, gain0ThLo_nxt;
    logic [7:0] satThHi_r, satThHi_nxt;
    logic [7:0] satThLo_r, satThLo_nxt;
    logic       ack_r, ack_nxt;
    logic [7:0] rdData_r, rdData_nxt;

    // Message framing and held outputs
    gct_state_t state_r, state_nxt;
    logic       hold0_r, hold0_nxt;
    logic       hold1_r, hold1_nxt;
    logic       sat_r, sat_nxt;
    logic       out0_r, out0_nxt;
    logic       out1_r, out1_nxt;
    logic       pin_r, pin_nxt;

    // Message flag and amplitude come from the analog side: synchronise
    logic        msgMeta_r, msgMeta_nxt;
    logic        msgSync_r, msgSync_nxt;
    logic        ptMeta_r, ptMeta_nxt;
    logic        ptSync_r, ptSync_nxt;
    logic [15:0] ampMeta_r, ampMeta_nxt;
    logic [15:0] ampSync_r, ampSync_nxt;

    logic [15:0] satThreshold;
    logic [15:0] gain0Threshold;
    logic [15:0] gain1Threshold;
    logic        satExceeded;
    logic        decided0;
    logic        decided1;
    logic        access;
    logic        msgStart;

    // Unsigned and strict, so an amplitude equal to the limit never trips
    function automatic logic exceeds(input logic [15:0] amp,
                                     input logic [15:0] limit);
        return amp > limit;
    endfunction

    assign satThreshold   = {satThHi_r, satThLo_r};
    assign gain0Threshold = {gain0ThHi_r, gain0ThLo_r};
    assign gain1Threshold = {gain1ThHi_r, gain1ThLo_r};
    assign satExceeded    = exceeds(ampSync_r, satThreshold);
    assign access         = wbCyc && wbStb && !ack_r;
    // A message starts on the first synced cycle seen while idle
    assign msgStart       = (state_r == GCT_IDLE) && msgSync_r;

    gct_channel_decide uDecide0 (
        .amplitude   (ampSync_r),
        .threshold   (gain0Threshold),
        .satExceeded (satExceeded),
        .modeSelect  (gainConfig_r[CFG_G0_MODE]),
        .forcedValue (gainConfig_r[CFG_G0_VAL]),
        .polarity    (gainConfig_r[CFG_G0_POL]),
        .decided     (decided0)
    );

    gct_channel_decide uDecide1 (
        .amplitude   (ampSync_r),
        .threshold   (gain1Threshold),
        .satExceeded (satExceeded),
        .modeSelect  (gainConfig_r[CFG_G1_MODE]),
        .forcedValue (gainConfig_r[CFG_G1_VAL]),
        .polarity    (gainConfig_r[CFG_G1_POL]),
        .decided     (decided1)
    );

    // Register writes and reads
    always_comb begin
        gain1ThHi_nxt  = gain1ThHi_r;
        gain1ThLo_nxt  = gain1ThLo_r;
        pinRouting_nxt = pinRouting_r;
        gainConfig_nxt = gainConfig_r;
        gain0ThHi_nxt  = gain0ThHi_r;
        gain0ThLo_nxt  = gain0ThLo_r;
        satThHi_nxt    = satThHi_r;
        satThLo_nxt    = satThLo_r;
        ack_nxt        = access;
        rdData_nxt     = BYTE_ZERO;
        if (access && wbWe && wbSel) begin
            if (wbAdr == ADDR_GAIN1_TH_HI) begin
                gain1ThHi_nxt = wbDatW;
            end else if (wbAdr == ADDR_GAIN1_TH_LO) begin
                gain1ThLo_nxt = wbDatW;
            end else if (wbAdr == ADDR_PIN_ROUTING) begin
                pinRouting_nxt = wbDatW & PIN_MASK;
            end else if (wbAdr == ADDR_GAIN_CONFIG) begin
                gainConfig_nxt = wbDatW & CFG_MASK;
            end else if (wbAdr == ADDR_GAIN0_TH_HI) begin
                gain0ThHi_nxt = wbDatW;
            end else if (wbAdr == ADDR_GAIN0_TH_LO) begin
                gain0ThLo_nxt = wbDatW;
            end else if (wbAdr == ADDR_SATURATION_THRESHOLD_HI) begin
                satThHi_nxt = wbDatW;
            end else if (wbAdr == ADDR_SATURATION_THRESHOLD_LO) begin
                satThLo_nxt = wbDatW;
            end
        end
        if (access && !wbWe) begin
            if (wbAdr == ADDR_GAIN1_TH_HI) begin
                rdData_nxt = gain1ThHi_r;
            end else if (wbAdr == ADDR_GAIN1_TH_LO) begin
                rdData_nxt = gain1ThLo_r;
            end else if (wbAdr == ADDR_PIN_ROUTING) begin
                rdData_nxt = pinRouting_r;
            end else if (wbAdr == ADDR_GAIN_CONFIG) begin
                rdData_nxt = gainConfig_r;
            end else if (wbAdr == ADDR_GAIN0_TH_HI) begin
                rdData_nxt = gain0ThHi_r;
            end else if (wbAdr == ADDR_GAIN0_TH_LO) begin
                rdData_nxt = gain0ThLo_r;
            end else if (wbAdr == ADDR_SATURATION_THRESHOLD_HI) begin
                rdData_nxt = satThHi_r;
            end else if (wbAdr == ADDR_SATURATION_THRESHOLD_LO) begin
                rdData_nxt = satThLo_r;
            end else if (wbAdr == ADDR_STATUS) begin
                rdData_nxt = BYTE_ZERO;
                rdData_nxt[ST_OUT0]  = out0_r;
                rdData_nxt[ST_OUT1]  = out1_r;
                rdData_nxt[ST_SAT]   = sat_r;
                rdData_nxt[ST_FRAME] = (state_r == GCT_HOLD);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            gain1ThHi_r  <= RST_GAIN1_TH_HI;
            gain1ThLo_r  <= RST_GAIN1_TH_LO;
            pinRouting_r <= RST_PIN_ROUTING;
            gainConfig_r <= RST_GAIN_CONFIG;
            gain0ThHi_r  <= RST_GAIN0_TH_HI;
            gain0ThLo_r  <= RST_GAIN0_TH_LO;
            satThHi_r    <= RST_SATURATION_THRESHOLD_HI;
            satThLo_r    <= RST_SATURATION_THRESHOLD_LO;
            ack_r        <= 1'b0;
            rdData_r     <= BYTE_ZERO;
        end else if (clockEnable) begin
            gain1ThHi_r  <= gain1ThHi_nxt;
            gain1ThLo_r  <= gain1ThLo_nxt;
            pinRouting_r <= pinRouting_nxt;
            gainConfig_r <= gainConfig_nxt;
            gain0ThHi_r  <= gain0ThHi_nxt;
            gain0ThLo_r  <= gain0ThLo_nxt;
            satThHi_r    <= satThHi_nxt;
            satThLo_r    <= satThLo_nxt;
            ack_r        <= ack_nxt;
            rdData_r     <= rdData_nxt;
        end
    end

    assign wbAck  = ack_r;
    assign wbDatR = rdData_r;

    // Input synchronisers: plain copies, nothing ahead of the first flop
    always_comb begin
        msgMeta_nxt = rxMessageActive;
        msgSync_nxt = msgMeta_r;
        ptMeta_nxt  = portTimerOutput;
        ptSync_nxt  = ptMeta_r;
        // Amplitude must be steady across two samples; no bus crossing
        ampMeta_nxt = rxAmplitude;
        ampSync_nxt = ampMeta_r;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            msgMeta_r <= 1'b0;
            msgSync_r <= 1'b0;
            ptMeta_r  <= 1'b0;
            ptSync_r  <= 1'b0;
            ampMeta_r <= '0;
            ampSync_r <= '0;
        end else if (clockEnable) begin
            msgMeta_r <= msgMeta_nxt;
            msgSync_r <= msgSync_nxt;
            ptMeta_r  <= ptMeta_nxt;
            ptSync_r  <= ptSync_nxt;
            ampMeta_r <= ampMeta_nxt;
            ampSync_r <= ampSync_nxt;
        end
    end

    // Automatic-mode decision latched on message start, held to message end
    always_comb begin
        state_nxt = state_r;
        hold0_nxt = hold0_r;
        hold1_nxt = hold1_r;
        sat_nxt   = sat_r;
        case (state_r)
            GCT_IDLE: begin
                if (msgStart) begin
                    hold0_nxt = decided0;
                    hold1_nxt = decided1;
                    sat_nxt   = satExceeded;
                    state_nxt = GCT_HOLD;
                end
            end
            GCT_HOLD: begin
                if (!msgSync_r) begin
                    state_nxt = GCT_IDLE;
                end
            end
            default: state_nxt = GCT_IDLE;
        endcase
        // Forced channels track software writes at once
        if (gainConfig_r[CFG_G0_MODE] != MODE_AUTO) begin
            hold0_nxt = decided0;
        end
        if (gainConfig_r[CFG_G1_MODE] != MODE_AUTO) begin
            hold1_nxt = decided1;
        end
        // Between messages automatic channels show no attenuation
        if (state_nxt == GCT_IDLE && state_r == GCT_IDLE) begin
            if (gainConfig_r[CFG_G0_MODE] == MODE_AUTO) begin
                hold0_nxt = ~gainConfig_r[CFG_G0_POL];
            end
            if (gainConfig_r[CFG_G1_MODE] == MODE_AUTO) begin
                hold1_nxt = ~gainConfig_r[CFG_G1_POL];
            end
        end
    end

    // Swap and pin routing
    always_comb begin
        if (pinRouting_r[PIN_SWAP]) begin
            out0_nxt = hold1_r;
            out1_nxt = hold0_r;
        end else begin
            out0_nxt = hold0_r;
            out1_nxt = hold1_r;
        end
        pin_nxt = pinRouting_r[PIN_SHARED] ? out1_nxt : ptSync_r;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= GCT_IDLE;
            hold0_r <= 1'b0;
            hold1_r <= 1'b0;
            sat_r   <= 1'b0;
            out0_r  <= 1'b0;
            out1_r  <= 1'b0;
            pin_r   <= 1'b0;
        end else if (clockEnable) begin
            state_r <= state_nxt;
            hold0_r <= hold0_nxt;
            hold1_r <= hold1_nxt;
            sat_r   <= sat_nxt;
            out0_r  <= out0_nxt;
            out1_r  <= out1_nxt;
            pin_r   <= pin_nxt;
        end
    end

    assign gainOutFirst  = out0_r;
    assign gainOutSecond = out1_r;
    assign sharedPinOut  = pin_r;
endmodule

// ===== src/gct_pkg.sv
// Package with register map, field positions and reset values
package gct_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam logic [15:0] ADDR_GAIN1_TH_HI  = 16'hFE5F;
    localparam logic [15:0] ADDR_GAIN1_TH_LO  = 16'hFE60;
    localparam logic [15:0] ADDR_PIN_ROUTING  = 16'hFE61;
    localparam logic [15:0] ADDR_GAIN_CONFIG  = 16'hFEB1;
    localparam logic [15:0] ADDR_GAIN0_TH_HI  = 16'hFEB2;
    localparam logic [15:0] ADDR_GAIN0_TH_LO  = 16'hFEB3;
    localparam logic [15:0] ADDR_SATURATION_THRESHOLD_HI    = 16'hFEB7;
    localparam logic [15:0] ADDR_SATURATION_THRESHOLD_LO    = 16'hFEB8;
    localparam logic [15:0] ADDR_STATUS       = 16'hFEC0;

    localparam logic [7:0] RST_GAIN1_TH_HI = 8'h40;
    localparam logic [7:0] RST_GAIN1_TH_LO = 8'h00;
    localparam logic [7:0] RST_PIN_ROUTING = 8'h00;
    localparam logic [7:0] RST_GAIN_CONFIG = 8'h24;
    localparam logic [7:0] RST_GAIN0_TH_HI = 8'h10;
    localparam logic [7:0] RST_GAIN0_TH_LO = 8'h00;
    localparam logic [7:0] RST_SATURATION_THRESHOLD_HI   = 8'h40;
    localparam logic [7:0] RST_SATURATION_THRESHOLD_LO   = 8'h00;

    // Configuration bit positions
    localparam int unsigned CFG_G0_POL  = 5;
    localparam int unsigned CFG_G0_VAL  = 4;
    localparam int unsigned CFG_G0_MODE = 3;
    localparam int unsigned CFG_G1_POL  = 2;
    localparam int unsigned CFG_G1_VAL  = 1;
    localparam int unsigned CFG_G1_MODE = 0;
    localparam logic [7:0]  CFG_MASK    = 8'h3F;
    localparam int unsigned PIN_SHARED  = 1;
    localparam int unsigned PIN_SWAP    = 0;
    localparam logic [7:0]  PIN_MASK    = 8'h03;

    // Status bit positions
    localparam int unsigned ST_OUT0  = 0;
    localparam int unsigned ST_OUT1  = 1;
    localparam int unsigned ST_SAT   = 2;
    localparam int unsigned ST_FRAME = 3;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic       MODE_AUTO = 1'b0;

    typedef enum logic {
        GCT_IDLE,
        GCT_HOLD
    } gct_state_t;
endpackage
